// ==== src/vector_map_pkg.sv ====
// Purpose: constants and types for the reset and interrupt vector mapper
// Assumes: program addresses are 16-bit word addresses
// Notes:   vector index 1 is reset, 2..35 are interrupt sources
//
// Overview of operation
// - every reset kind uses vector one at 0x0000 when fuse unprogrammed
// - external requests zero..seven map to 0x0002..0x0010 in steps of two
// - timer two compare/overflow 0x0012/0x0014; timer one 0x0016..0x001C
// - timer zero compare 0x001E, overflow 0x0020
// - serial transfer done 0x0022; first serial port 0x0024..0x0028
// - conversion done 0x002A, eeprom ready 0x002C, comparator 0x002E
// - timer one compare C 0x0030; timer three 0x0032..0x003A
// - second serial port 0x003C..0x0040; two-wire 0x0042; store ready 0x0044
// - programmed boot fuse starts execution at boot reset address
// - vector select set adds boot section start to every interrupt vector
// - legacy mode removes sources at 0x0030..0x0044 entirely
// - vector base is 0x0002, or boot address plus 0x0002 when selected
// - boot fuse reads 1 unprogrammed, 0 programmed
// - eight kilobyte boot section gives boot address 0xF000, vectors 0xF002
package vector_map_pkg;

  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned NUM_SRC     = 34;
  localparam int unsigned SRC_IDX_W   = 6;
  localparam int unsigned LEGACY_SRC  = 23;  // sources 0..22 exist in legacy mode
  localparam logic [ADDR_W-1:0] RESET_ADDR_DEF = 16'h0000;
  localparam logic [ADDR_W-1:0] VEC_BASE_OFS   = 16'h0002;
  localparam logic [ADDR_W-1:0] BOOT_ADDR_8K   = 16'hf000;
  localparam logic FUSE_UNPROGRAMMED = 1'b1;
  localparam logic FUSE_PROGRAMMED   = 1'b0;

  // default table offsets, one per source index 0..33
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_0            = 16'h0002;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_1            = 16'h0004;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_2            = 16'h0006;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_3            = 16'h0008;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_4            = 16'h000a;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_5            = 16'h000c;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_6            = 16'h000e;
  localparam logic [ADDR_W-1:0] OFS_EXT_REQ_7            = 16'h0010;
  localparam logic [ADDR_W-1:0] OFS_T2_MATCH             = 16'h0012;
  localparam logic [ADDR_W-1:0] OFS_T2_WRAP              = 16'h0014;
  localparam logic [ADDR_W-1:0] OFS_T1_CAPTURE           = 16'h0016;
  localparam logic [ADDR_W-1:0] OFS_T1_MATCH_A           = 16'h0018;
  localparam logic [ADDR_W-1:0] OFS_T1_MATCH_B           = 16'h001a;
  localparam logic [ADDR_W-1:0] OFS_T1_WRAP              = 16'h001c;
  localparam logic [ADDR_W-1:0] OFS_T0_MATCH             = 16'h001e;
  localparam logic [ADDR_W-1:0] OFS_T0_WRAP              = 16'h0020;
  localparam logic [ADDR_W-1:0] OFS_SERIAL_TRANSFER_DONE = 16'h0022;
  localparam logic [ADDR_W-1:0] OFS_PORT0_RX_DONE        = 16'h0024;
  localparam logic [ADDR_W-1:0] OFS_PORT0_TX_DATA_EMPTY  = 16'h0026;
  localparam logic [ADDR_W-1:0] OFS_PORT0_TX_DONE        = 16'h0028;
  localparam logic [ADDR_W-1:0] OFS_CONV_DONE            = 16'h002a;
  localparam logic [ADDR_W-1:0] OFS_EEPROM_READY_EVENT   = 16'h002c;
  localparam logic [ADDR_W-1:0] OFS_COMPARATOR           = 16'h002e;
  localparam logic [ADDR_W-1:0] OFS_T1_MATCH_C           = 16'h0030;
  localparam logic [ADDR_W-1:0] OFS_T3_CAPTURE           = 16'h0032;
  localparam logic [ADDR_W-1:0] OFS_T3_MATCH_A           = 16'h0034;
  localparam logic [ADDR_W-1:0] OFS_T3_MATCH_B           = 16'h0036;
  localparam logic [ADDR_W-1:0] OFS_T3_MATCH_C           = 16'h0038;
  localparam logic [ADDR_W-1:0] OFS_T3_WRAP              = 16'h003a;
  localparam logic [ADDR_W-1:0] OFS_PORT1_RX_DONE        = 16'h003c;
  localparam logic [ADDR_W-1:0] OFS_PORT1_TX_DATA_EMPTY  = 16'h003e;
  localparam logic [ADDR_W-1:0] OFS_PORT1_TX_DONE        = 16'h0040;
  localparam logic [ADDR_W-1:0] OFS_TWO_WIRE_PORT        = 16'h0042;
  localparam logic [ADDR_W-1:0] OFS_PROGRAM_STORE_READY  = 16'h0044;

  typedef struct packed {
    logic                 valid;
    logic [SRC_IDX_W-1:0] src;
    logic [ADDR_W-1:0]    addr;
  } vector_req_s;

endpackage : vector_map_pkg

// ==== src/lowest_pending.sv ====
// Purpose: pick the lowest-numbered set bit of a request vector
// Assumes: purely combinational
// Notes:   index 0 has highest priority
`timescale 1ns/1ns
`default_nettype none
module lowest_pending #(
  parameter int unsigned N   = 34,
  parameter int unsigned IDX = 6
) (
  input  wire logic [N-1:0]   req_i,
  output logic                any_o,
  output logic [IDX-1:0]      idx_o
);
  initial begin
    if (N > (1 << IDX)) $error("index width too small");
  end

  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        any_o = 1'b1;
        idx_o = IDX'(i);
      end
    end
  end
endmodule // lowest_pending
`default_nettype wire

// ==== src/reset_irq_vector_mapper.sv ====
// Purpose: map reset and 34 interrupt sources to program vector addresses
// Assumes: requests already enabled and synchronous to sys_clk_i
// Notes:   vector output registered; boot address is a parameter
`timescale 1ns/1ns
`default_nettype none
module reset_irq_vector_mapper
  import vector_map_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = BOOT_ADDR_8K
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  input  wire logic               boot_reset_fuse_i,
  input  wire logic               vector_base_select_i,
  input  wire logic               legacy_mode_i,
  input  wire logic [NUM_SRC-1:0] irq_req_i,
  input  wire logic               vector_taken_i,
  output logic [ADDR_W-1:0]       reset_addr_o,
  output logic [ADDR_W-1:0]       vector_base_o,
  output logic                    vector_valid_o,
  output logic [SRC_IDX_W-1:0]    vector_src_o,
  output logic [ADDR_W-1:0]       vector_addr_o
);

  // ----------------------------------------------------------------
  // checks and decode
  // ----------------------------------------------------------------
  initial begin
    if (BOOT_RESET_ADDR[0] != 1'b0) $error("boot address must be even");
  end

  function automatic logic fuse_programmed(input logic fuse);
    return fuse == FUSE_PROGRAMMED;
  endfunction

  // ----------------------------------------------------------------
  // source classes
  // ----------------------------------------------------------------
  function automatic logic upper_source(input int unsigned idx);
    return idx >= LEGACY_SRC;
  endfunction

  // ----------------------------------------------------------------
  // vector table
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] vector_offset(input logic [SRC_IDX_W-1:0] idx);
    logic [ADDR_W-1:0] ofs;
    ofs = VEC_BASE_OFS;
    case (idx)
      // external requests
      6'h00:   ofs = OFS_EXT_REQ_0;
      6'h01:   ofs = OFS_EXT_REQ_1;
      6'h02:   ofs = OFS_EXT_REQ_2;
      6'h03:   ofs = OFS_EXT_REQ_3;
      6'h04:   ofs = OFS_EXT_REQ_4;
      6'h05:   ofs = OFS_EXT_REQ_5;
      6'h06:   ofs = OFS_EXT_REQ_6;
      6'h07:   ofs = OFS_EXT_REQ_7;

      // timers two and one
      6'h08:   ofs = OFS_T2_MATCH;
      6'h09:   ofs = OFS_T2_WRAP;
      6'h0a:   ofs = OFS_T1_CAPTURE;
      6'h0b:   ofs = OFS_T1_MATCH_A;
      6'h0c:   ofs = OFS_T1_MATCH_B;
      6'h0d:   ofs = OFS_T1_WRAP;

      // timer zero
      6'h0e:   ofs = OFS_T0_MATCH;
      6'h0f:   ofs = OFS_T0_WRAP;

      // serial peripheral and first serial port
      6'h10:   ofs = OFS_SERIAL_TRANSFER_DONE;
      6'h11:   ofs = OFS_PORT0_RX_DONE;
      6'h12:   ofs = OFS_PORT0_TX_DATA_EMPTY;
      6'h13:   ofs = OFS_PORT0_TX_DONE;

      // converter, eeprom, comparator
      6'h14:   ofs = OFS_CONV_DONE;
      6'h15:   ofs = OFS_EEPROM_READY_EVENT;
      6'h16:   ofs = OFS_COMPARATOR;

      // timer one match c and timer three
      6'h17:   ofs = OFS_T1_MATCH_C;
      6'h18:   ofs = OFS_T3_CAPTURE;
      6'h19:   ofs = OFS_T3_MATCH_A;
      6'h1a:   ofs = OFS_T3_MATCH_B;
      6'h1b:   ofs = OFS_T3_MATCH_C;
      6'h1c:   ofs = OFS_T3_WRAP;

      // second serial port, two-wire, store ready
      6'h1d:   ofs = OFS_PORT1_RX_DONE;
      6'h1e:   ofs = OFS_PORT1_TX_DATA_EMPTY;
      6'h1f:   ofs = OFS_PORT1_TX_DONE;
      6'h20:   ofs = OFS_TWO_WIRE_PORT;
      6'h21:   ofs = OFS_PROGRAM_STORE_READY;
      default: ofs = VEC_BASE_OFS;
    endcase
    return ofs;
  endfunction

  // ----------------------------------------------------------------
  // reset and vector base
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] reset_addr_d;
  logic [ADDR_W-1:0] base_d;
  logic [ADDR_W-1:0] reset_addr_q;
  logic [ADDR_W-1:0] base_q;

  // all reset kinds share one vector
  assign reset_addr_d = fuse_programmed(boot_reset_fuse_i) ? BOOT_RESET_ADDR
                                                           : RESET_ADDR_DEF;
  // base independent of reset location
  assign base_d = vector_base_select_i ? ADDR_W'(BOOT_RESET_ADDR + VEC_BASE_OFS)
                                       : VEC_BASE_OFS;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reset_addr_q <= RESET_ADDR_DEF;
    end else begin
      reset_addr_q <= reset_addr_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      base_q <= VEC_BASE_OFS;
    end else begin
      base_q <= base_d;
    end
  end

  assign reset_addr_o  = reset_addr_q;
  assign vector_base_o = base_q;

  // ----------------------------------------------------------------
  // source masking and priority
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0]   live_req;
  logic                 any_req;
  logic [SRC_IDX_W-1:0] win_idx;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_mask
      if (!upper_source(g)) begin : g_base
        assign live_req[g] = irq_req_i[g];
      end else begin : g_upper
        assign live_req[g] = irq_req_i[g] & ~legacy_mode_i;
      end
    end
  endgenerate

  lowest_pending #(
    .N   (NUM_SRC),
    .IDX (SRC_IDX_W)
  ) u_pick (
    .req_i (live_req),
    .any_o (any_req),
    .idx_o (win_idx)
  );

  // ----------------------------------------------------------------
  // vector address
  // ----------------------------------------------------------------
  // source i is vector i+2; table step of two words from base
  vector_req_s       vec_d;
  vector_req_s       vec_q;
  logic [ADDR_W-1:0] reloc_d;
  logic              load_vec;

  // table moves with the vector select bit only
  assign reloc_d = vector_base_select_i ? BOOT_RESET_ADDR : '0;

  always_comb begin
    vec_d.valid = any_req;
    vec_d.src   = win_idx;
    vec_d.addr  = ADDR_W'(reloc_d + vector_offset(win_idx));
  end

  // ----------------------------------------------------------------
  // output register
  // ----------------------------------------------------------------
  assign load_vec = !vec_q.valid || vector_taken_i;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vec_q <= '0;
    end else if (load_vec) begin
      vec_q <= vec_d;
    end
  end

  assign vector_valid_o = vec_q.valid;
  assign vector_src_o   = vec_q.src;
  assign vector_addr_o  = vec_q.addr;

  // ----------------------------------------------------------------
  // elaboration checks of the table
  // ----------------------------------------------------------------
  initial begin
    if (32'(BOOT_RESET_ADDR) + 32'(OFS_PROGRAM_STORE_READY) > 32'hffff) begin
      $error("relocated table wraps");
    end
    if (LEGACY_SRC > NUM_SRC) begin
      $error("legacy split beyond source count");
    end
  end

  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_table
      initial begin
        if (vector_offset(SRC_IDX_W'(g)) != ADDR_W'(VEC_BASE_OFS + 2 * g)) begin
          $error("table step broken");
        end
        if (upper_source(g) != (vector_offset(SRC_IDX_W'(g)) >= OFS_T1_MATCH_C)) begin
          $error("legacy split broken");
        end
      end
    end
  endgenerate

endmodule // reset_irq_vector_mapper
`default_nettype wire

// ==== verif/vector_map_chk.sv ====
// Purpose: port checker of the vector mapper
// Assumes: sync reset
// Notes:   bound below
`timescale 1ns/1ns
`default_nettype none
module vector_map_chk
  import vector_map_pkg::*;
#(parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = BOOT_ADDR_8K) (
  input wire logic sys_clk_i, rst_i, boot_reset_fuse_i, vector_base_select_i,
  input wire logic legacy_mode_i, vector_taken_i, vector_valid_o,
  input wire logic [NUM_SRC-1:0] irq_req_i,
  input wire logic [SRC_IDX_W-1:0] vector_src_o,
  input wire logic [ADDR_W-1:0] reset_addr_o, vector_base_o, vector_addr_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [NUM_SRC-1:0] m;
  logic               ld;
  assign m = irq_req_i & ({NUM_SRC{1'b1}} >> (legacy_mode_i ? NUM_SRC - LEGACY_SRC : 0));
  assign ld = !rst_i && (!vector_valid_o || vector_taken_i);
  AST_RST_ADDR: assert property (!$past(rst_i) |-> reset_addr_o ==
    ($past(boot_reset_fuse_i) ? 16'h0000 : BOOT_RESET_ADDR)) else $error("bad reset address");
  AST_BASE: assert property (!$past(rst_i) |-> vector_base_o ==
    ($past(vector_base_select_i) ? BOOT_RESET_ADDR + 16'h0002 : 16'h0002)) else $error("bad base");
  AST_RST_VAL: assert property ($past(rst_i) |-> !vector_valid_o && vector_base_o == 16'h0002)
    else $error("bad reset state");
  AST_ANY: assert property ($past(ld) |-> vector_valid_o == |$past(m))
    else $error("bad valid");
  AST_LOW: assert property (vector_valid_o && $past(ld) |->
    ($past(m) << (NUM_SRC - vector_src_o)) == 0) else $error("not lowest");
  AST_SRC: assert property (vector_valid_o && $past(ld) |-> 1'($past(m) >> vector_src_o))
    else $error("source not pending");
  AST_ADDR: assert property (vector_valid_o && $past(ld) |-> vector_addr_o ==
    ($past(vector_base_select_i) ? BOOT_RESET_ADDR : 16'h0000) + 16'h0002 + {9'h0, vector_src_o, 1'b0})
    else $error("bad vector address");
  AST_HOLD: assert property (vector_valid_o && !vector_taken_i |=> vector_valid_o &&
    $stable(vector_src_o) && $stable(vector_addr_o)) else $error("vector not held");
endmodule // vector_map_chk
bind reset_irq_vector_mapper vector_map_chk #(.BOOT_RESET_ADDR(BOOT_RESET_ADDR)) vector_map_chk_i (
  .sys_clk_i, .rst_i, .boot_reset_fuse_i, .vector_base_select_i, .legacy_mode_i, .vector_taken_i,
  .vector_valid_o, .irq_req_i, .vector_src_o, .reset_addr_o, .vector_base_o, .vector_addr_o);
`default_nettype wire

// ==== verif/core_fetch_model.sv ====
// Purpose: core fetch side, takes vectors
// Assumes: lat_i from bench
// Notes:   pulses taken_o after lat_i cycles
`timescale 1ns/1ns
`default_nettype none
module core_fetch_model (
  input  wire logic       sys_clk_i, rst_i, valid_i,
  input  wire logic [1:0] lat_i,
  output var logic        taken_o
);
  logic [1:0] cnt_q;
  always_ff @(posedge sys_clk_i) begin
    taken_o <= !rst_i && valid_i && !taken_o && cnt_q >= lat_i;
    cnt_q <= (rst_i || taken_o || !valid_i) ? 2'h0 : cnt_q + 2'h1;
  end
endmodule // core_fetch_model
`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: test of vector mapper
// Assumes: core model in loop
// Notes:   checks at falling edge
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import vector_map_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, boot_reset_fuse_i = 1, vector_base_select_i = 0;
  logic legacy_mode_i = 0, vector_taken_i, vector_valid_o, ld = 1;
  logic [NUM_SRC-1:0] irq_req_i = '0;
  logic [SRC_IDX_W-1:0] vector_src_o;
  logic [ADDR_W-1:0] reset_addr_o, vector_base_o, vector_addr_o, b;
  logic [31:0] r;
  logic [22:0] s;
  logic [1:0] lat = 0;
  int seed = 32'haa85f380, mismatches = 0, total_checks = 0;
  vector_req_s e;
  reset_irq_vector_mapper reset_irq_vector_mapper_i (.sys_clk_i, .rst_i, .boot_reset_fuse_i,
    .vector_base_select_i, .legacy_mode_i, .irq_req_i, .vector_taken_i, .reset_addr_o,
    .vector_base_o, .vector_valid_o, .vector_src_o, .vector_addr_o);
  core_fetch_model core_fetch_model_i (.sys_clk_i, .rst_i, .valid_i(vector_valid_o),
    .lat_i(lat), .taken_o(vector_taken_i));
  initial forever #4 sys_clk_i = ~sys_clk_i;
  function automatic vector_req_s exp_vec(logic [NUM_SRC-1:0] q, logic [15:0] a, logic g);
    exp_vec = '0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (q[k] && !(g && k >= LEGACY_SRC)) exp_vec = {1'b1, 6'(k), a + 16'(2 * k)};
    end
  endfunction
  task automatic chk(string n, logic [22:0] x, logic [22:0] v);
    total_checks++;
    if (v !== x) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, x, v);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #40000;
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge sys_clk_i);
    rst_i = 0;
    for (int i = 0; i < 700; i++) begin
      @(negedge sys_clk_i);
      b = vector_base_select_i ? BOOT_ADDR_8K + 16'h0002 : 16'h0002;
      e = exp_vec(irq_req_i, b, legacy_mode_i);
      s = {vector_valid_o, e.valid ? {vector_src_o, vector_addr_o} : 22'h0};
      chk("base", 23'(b), 23'(vector_base_o));
      chk("reset", boot_reset_fuse_i ? 23'h0 : 23'(BOOT_ADDR_8K), 23'(reset_addr_o));
      if (ld) chk("vector", e, s);
      ld = !vector_valid_o || vector_taken_i;
      r = $random(seed);
      lat = i < 272 ? 2'h0 : r[8:7];
      legacy_mode_i = i < 272 ? i >= 136 : r[11];
      boot_reset_fuse_i = r[12];
      vector_base_select_i = r[13];
      if (i < 272) irq_req_i = NUM_SRC'(1) << (i / 4 % 34);
      else irq_req_i = NUM_SRC'({$random(seed), r} << (r[5:0] % 34)) & {NUM_SRC{r[6]}};
    end
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
